// ---- hdl/ext_irq_conditioner.sv ----
// top: external interrupt conditioner with axi4-lite registers
// Notes on behaviour
// - polarity bit per input: 0 low, 1 high
// - sensitivity bit: 1 edge, 0 level
// - three-bit field selects port 0 pin
// - pin monitoring never disturbs crossbar peripherals
// - pending flags at timer control bits 1,3
// - edge mode: vectoring clears the pending flag
// - level mode: flag follows active input level
`timescale 1ns/1ps
`default_nettype none
module ext_irq_conditioner
    import ext_irq_pkg::*;
(
    // clock and reset
    input  wire logic                   REF_CLK,
    input  wire logic                   RST_B,
    // port 0 pins
    input  wire logic [PORT_WIDTH-1:0]  PORT0_PINS,
    // cpu vectoring strobes, same clock
    input  wire logic                   VECTOR_A,
    input  wire logic                   VECTOR_B,
    // pending flags to the cpu
    output logic                        IRQ_A_PENDING,
    output logic                        IRQ_B_PENDING,
    output logic                        IRQ,
    // axi4-lite write address
    input  wire logic                   S_AXI_AWVALID,
    output logic                        S_AXI_AWREADY,
    input  wire logic [ADDR_WIDTH-1:0]  S_AXI_AWADDR,
    // axi4-lite write data
    input  wire logic                   S_AXI_WVALID,
    output logic                        S_AXI_WREADY,
    input  wire logic [DATA_WIDTH-1:0]  S_AXI_WDATA,
    input  wire logic [3:0]             S_AXI_WSTRB,
    // axi4-lite write response
    output logic                        S_AXI_BVALID,
    input  wire logic                   S_AXI_BREADY,
    output logic [1:0]                  S_AXI_BRESP,
    // axi4-lite read address
    input  wire logic                   S_AXI_ARVALID,
    output logic                        S_AXI_ARREADY,
    input  wire logic [ADDR_WIDTH-1:0]  S_AXI_ARADDR,
    // axi4-lite read data
    output logic                        S_AXI_RVALID,
    input  wire logic                   S_AXI_RREADY,
    output logic [DATA_WIDTH-1:0]       S_AXI_RDATA,
    output logic [1:0]                  S_AXI_RRESP
);
    function automatic logic mapped(input logic [ADDR_WIDTH-1:0] a);
        mapped = (a == ADDR_PIN_POL) || (a == ADDR_TCTRL) || (a == ADDR_IRQ_STATUS)
              || (a == ADDR_IRQ_ENABLE) || (a == ADDR_IRQ_CLEAR) || (a == ADDR_VECTOR_ACK);
    endfunction

    logic [PORT_WIDTH-1:0]  pins_meta_q;
    logic [PORT_WIDTH-1:0]  pins_sync_q;
    logic [7:0]             pin_pol_q;
    logic [1:0]             edge_mode_q;
    logic [NUM_IRQ-1:0]     status_q;
    logic [NUM_IRQ-1:0]     enable_q;
    logic [NUM_IRQ-1:0]     soft_ack_q;
    logic [NUM_IRQ-1:0]     pend;
    logic [NUM_IRQ-1:0]     evt;
    logic                   aw_held_q;
    logic                   w_held_q;
    logic [ADDR_WIDTH-1:0]  awaddr_q;
    logic [DATA_WIDTH-1:0]  wdata_q;
    logic [3:0]             wstrb_q;
    logic                   wr_commit;
    logic [7:0]             tctrl;

    irq_cfg_if cfg_a ();
    irq_cfg_if cfg_b ();

    // two-flop synchroniser: pins are asynchronous to REF_CLK
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            // idle-high reset level: the active-low reset config sees no false request
            pins_meta_q <= '1;
            pins_sync_q <= '1;
        end else begin
            pins_meta_q <= PORT0_PINS;
            pins_sync_q <= pins_meta_q;
        end
    end

    assign cfg_a.pin_select = pin_pol_q[POS_A_SEL +: SEL_WIDTH];
    assign cfg_a.polarity   = pin_pol_q[POS_A_POL];
    assign cfg_a.edge_mode  = edge_mode_q[0];
    assign cfg_a.vector_ack = VECTOR_A | soft_ack_q[0];
    assign cfg_b.pin_select = pin_pol_q[POS_B_SEL +: SEL_WIDTH];
    assign cfg_b.polarity   = pin_pol_q[POS_B_POL];
    assign cfg_b.edge_mode  = edge_mode_q[1];
    assign cfg_b.vector_ack = VECTOR_B | soft_ack_q[1];
    assign pend             = {cfg_b.pending, cfg_a.pending};
    assign evt              = {cfg_b.edge_event, cfg_a.edge_event};

    irq_channel u_chan_a (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .pins_sync (pins_sync_q),
        .cfg       (cfg_a)
    );

    irq_channel u_chan_b (
        .clk       (REF_CLK),
        .rst_b     (RST_B),
        .pins_sync (pins_sync_q),
        .cfg       (cfg_b)
    );

    // write channel: address and data accepted independently, in either order
    assign wr_commit = aw_held_q && w_held_q && !S_AXI_BVALID;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= S_AXI_AWVALID && !S_AXI_AWREADY && !aw_held_q && !S_AXI_BVALID;
            S_AXI_WREADY  <= S_AXI_WVALID && !S_AXI_WREADY && !w_held_q && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_q <= 1'b1;
                wdata_q  <= S_AXI_WDATA;
                wstrb_q  <= S_AXI_WSTRB;
            end
            if (wr_commit) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // registers are written only once both halves sit in the holding flops
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_pol_q   <= PIN_POL_RESET;
            edge_mode_q <= '0;
            enable_q    <= '0;
            soft_ack_q  <= '0;
        end else begin
            soft_ack_q <= '0;
            if (wr_commit && wstrb_q[0]) begin
                unique case (awaddr_q)
                    ADDR_PIN_POL:    pin_pol_q   <= wdata_q[7:0];
                    ADDR_TCTRL:      edge_mode_q <= {wdata_q[POS_B_EDGE], wdata_q[POS_A_EDGE]};
                    ADDR_IRQ_ENABLE: enable_q    <= wdata_q[NUM_IRQ-1:0];
                    ADDR_VECTOR_ACK: soft_ack_q  <= wdata_q[NUM_IRQ-1:0];
                    default:         ;
                endcase
            end
        end
    end

    // sticky status: a new event in the clearing cycle wins
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_q <= '0;
        end else begin
            for (int i = 0; i < NUM_IRQ; i++) begin
                if (evt[i]) begin
                    status_q[i] <= 1'b1;
                end else if (wr_commit && wstrb_q[0] && awaddr_q == ADDR_IRQ_CLEAR && wdata_q[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            IRQ_A_PENDING <= 1'b0;
            IRQ_B_PENDING <= 1'b0;
            IRQ           <= 1'b0;
        end else begin
            IRQ_A_PENDING <= pend[0];
            IRQ_B_PENDING <= pend[1];
            IRQ           <= |(status_q & enable_q);
        end
    end

    always_comb begin
        tctrl             = TCTRL_RESET;
        tctrl[POS_A_EDGE] = edge_mode_q[0];
        tctrl[POS_A_PEND] = pend[0];
        tctrl[POS_B_EDGE] = edge_mode_q[1];
        tctrl[POS_B_PEND] = pend[1];
    end

    // read channel: one cycle to accept, data the next
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
                S_AXI_RDATA  <= '0;
                unique case (S_AXI_ARADDR)
                    ADDR_PIN_POL:    S_AXI_RDATA[7:0]         <= pin_pol_q;
                    ADDR_TCTRL:      S_AXI_RDATA[7:0]         <= tctrl;
                    ADDR_IRQ_STATUS: S_AXI_RDATA[NUM_IRQ-1:0] <= status_q;
                    ADDR_IRQ_ENABLE: S_AXI_RDATA[NUM_IRQ-1:0] <= enable_q;
                    default:         ;
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule : ext_irq_conditioner
`default_nettype wire

// ---- hdl/ext_irq_pkg.sv ----
// package: register map, field layout and reset values of the external interrupt conditioner
package ext_irq_pkg;
    localparam int          PORT_WIDTH      = 8;
    localparam int          ADDR_WIDTH      = 8;
    localparam int          DATA_WIDTH      = 32;
    // register byte addresses
    localparam logic [7:0]  ADDR_PIN_POL    = 8'hE4;
    localparam logic [7:0]  ADDR_TCTRL      = 8'h88;
    localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h90;
    localparam logic [7:0]  ADDR_IRQ_ENABLE = 8'h94;
    localparam logic [7:0]  ADDR_IRQ_CLEAR  = 8'h98;
    localparam logic [7:0]  ADDR_VECTOR_ACK = 8'h9C;
    // pin/polarity configuration fields
    localparam int          POS_B_POL       = 7;
    localparam int          POS_B_SEL       = 4;
    localparam int          POS_A_POL       = 3;
    localparam int          POS_A_SEL       = 0;
    localparam int          SEL_WIDTH       = 3;
    localparam logic [7:0]  PIN_POL_RESET   = 8'h01;
    // timer control fields
    localparam int          POS_A_EDGE      = 0;
    localparam int          POS_A_PEND      = 1;
    localparam int          POS_B_EDGE      = 2;
    localparam int          POS_B_PEND      = 3;
    localparam logic [7:0]  TCTRL_RESET     = 8'h00;
    // status layout: bit 0 input a event, bit 1 input b event
    localparam int          NUM_IRQ         = 2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : ext_irq_pkg

// ---- hdl/irq_cfg_if.sv ----
// interface: per-input configuration and pending flags between the top and the channel
`timescale 1ns/1ps
`default_nettype none
interface irq_cfg_if;
    import ext_irq_pkg::*;
    logic [SEL_WIDTH-1:0]  pin_select;
    logic                  polarity;
    logic                  edge_mode;
    logic                  vector_ack;
    logic                  pending;
    logic                  edge_event;
    modport ctrl (output pin_select, output polarity, output edge_mode, output vector_ack,
                  input pending, input edge_event);
    modport chan (input pin_select, input polarity, input edge_mode, input vector_ack,
                  output pending, output edge_event);
endinterface : irq_cfg_if
`default_nettype wire

// ---- hdl/irq_channel.sv ----
// one external interrupt channel: pin select, polarity, edge/level detect, pending flag
`timescale 1ns/1ps
`default_nettype none
module irq_channel
    import ext_irq_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // synchronised port 0 pins
    input  wire logic [PORT_WIDTH-1:0]  pins_sync,
    // configuration and flags
    irq_cfg_if.chan                     cfg
);
    logic active;
    logic active_q;
    logic pend_q;

    // pins are only read, so whatever the crossbar routes to them is untouched
    assign active = pins_sync[cfg.pin_select] ~^ cfg.polarity;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active;
        end
    end

    // a new edge in the vectoring cycle wins over the clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
        end else if (cfg.edge_mode) begin
            if (active && !active_q) begin
                pend_q <= 1'b1;
            end else if (cfg.vector_ack) begin
                pend_q <= 1'b0;
            end
        end else begin
            pend_q <= active;
        end
    end

    assign cfg.pending    = pend_q;
    // status sees inactive-to-active transitions in either mode
    assign cfg.edge_event = active && !active_q;
endmodule : irq_channel
`default_nettype wire

// ---- verification/ext_irq_conditioner_checker.sv ----
// checker: bus handshake and pending flag assertions for the conditioner
`timescale 1ns/1ps
`default_nettype none
module ext_irq_conditioner_checker (
    // clock, reset, cpu side
    input wire logic        REF_CLK,
    input wire logic        RST_B,
    input wire logic [7:0]  PORT0_PINS,
    input wire logic        VECTOR_A,
    input wire logic        VECTOR_B,
    input wire logic        IRQ_A_PENDING,
    input wire logic        IRQ_B_PENDING,
    // register bus
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    logic [7:0] pins_q;
    logic [3:0] quiet_q;
    // quiet span: pins steady, no vectoring, no register write; sync and updates must settle
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pins_q  <= 8'h00;
            quiet_q <= 4'h0;
        end else begin
            pins_q <= PORT0_PINS;
            if (PORT0_PINS != pins_q || VECTOR_A || VECTOR_B || S_AXI_AWVALID)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end
    sequence s_write_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_read_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    a_aw_ready_cause: assert property ($rose(S_AXI_AWREADY) |-> $past(S_AXI_AWVALID))
        else $error("write address ready without a request");
    a_aw_ready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("write address ready longer than one cycle");
    a_w_ready_pulse: assert property (S_AXI_WREADY |=> !S_AXI_WREADY)
        else $error("write data ready longer than one cycle");
    a_write_answer: assert property (s_write_taken |-> ##[1:3] S_AXI_BVALID)
        else $error("write response late");
    a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped before ready");
    a_no_aw_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("write address taken while response pending");
    a_read_answer: assert property (s_read_taken |=> S_AXI_RVALID)
        else $error("read data late");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data changed before ready");
    a_pend_quiet: assert property (quiet_q >= 4'h8 |->
        $stable(IRQ_A_PENDING) && $stable(IRQ_B_PENDING))
        else $error("pending flag moved without cause");
endmodule // ext_irq_conditioner_checker
bind ext_irq_conditioner ext_irq_conditioner_checker chk_i (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .PORT0_PINS(PORT0_PINS),
    .VECTOR_A(VECTOR_A), .VECTOR_B(VECTOR_B),
    .IRQ_A_PENDING(IRQ_A_PENDING), .IRQ_B_PENDING(IRQ_B_PENDING),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA));
`default_nettype wire

// ---- verification/irq_source_model.sv ----
// model: external interrupt sources on the port pins and the cpu vectoring strobes
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    // clock
    input  wire logic  clk,
    // sources and cpu
    output logic [7:0] pins,
    output logic       vec_a,
    output logic       vec_b
);
    initial begin
        pins  = 8'hFF;
        vec_a = 1'b0;
        vec_b = 1'b0;
    end
    // pins stay owned by the sources; drive sets the pin levels at the next clock and keeps them until the next drive
    task automatic drive(input logic [7:0] v);
        @(posedge clk);
        pins <= v;
    endtask
    task automatic vector(input logic b);
        @(posedge clk);
        if (b) vec_b <= 1'b1;
        else vec_a <= 1'b1;
        @(posedge clk);
        vec_a <= 1'b0;
        vec_b <= 1'b0;
    endtask
endmodule // irq_source_model
`default_nettype wire

// ---- verification/test_ext_irq_conditioner.sv ----
// testbench: register, level, edge and interrupt scenarios for the conditioner
`timescale 1ns/1ps
`default_nettype none
module test_ext_irq_conditioner;
    import ext_irq_pkg::*;
    logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        vec_a, vec_b, pend_a, pend_b, irq, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr, pins;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  wstrb;
    int          num_errors = 0;
    int          check_count = 0;
    ext_irq_conditioner uut (.REF_CLK(clk), .RST_B(rst_b), .PORT0_PINS(pins),
        .VECTOR_A(vec_a), .VECTOR_B(vec_b), .IRQ_A_PENDING(pend_a), .IRQ_B_PENDING(pend_b),
        .IRQ(irq), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp));
    irq_source_model src (.clk(clk), .pins(pins), .vec_a(vec_a), .vec_b(vec_b));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk("bvalid", bvalid, 1'b1);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        chk("rvalid", rvalid, 1'b1);
        chk("rdata", rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    // sync chain plus flag register take about four cycles
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_PIN_POL, 32'h01, RESP_OKAY);
        rd(ADDR_TCTRL, 32'h00, RESP_OKAY);
        rd(8'h00, 32'h00, RESP_SLVERR);
        wr(8'h40, 32'h00, RESP_SLVERR);
        src.drive(8'hFD);
        settle;
        chk("pend_a", pend_a, 1'b1);
        rd(ADDR_TCTRL, 32'h02, RESP_OKAY);
        src.drive(8'hFF);
        settle;
        chk("pend_a", pend_a, 1'b0);
        // b watches the mirror pin so a wrong select shows on one of the flags
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_PIN_POL, {24'h0, 1'b1, 3'(7 - i), 1'b1, i[2:0]}, RESP_OKAY);
            src.drive(8'h01 << i);
            settle;
            chk("pend_a", pend_a, 1'b1);
            chk("pend_b", pend_b, 1'b0);
            src.drive(8'h00);
            settle;
            chk("pend_a", pend_a, 1'b0);
        end
        wr(ADDR_TCTRL, 32'h05, RESP_OKAY);
        wr(ADDR_PIN_POL, 32'hD9, RESP_OKAY);
        wr(ADDR_IRQ_CLEAR, 32'h03, RESP_OKAY);
        wr(ADDR_IRQ_ENABLE, 32'h02, RESP_OKAY);
        src.drive(8'h22);
        repeat (2) @(posedge clk);
        src.drive(8'h00);
        settle;
        chk("pend_a", pend_a, 1'b1);
        chk("pend_b", pend_b, 1'b1);
        chk("irq", irq, 1'b1);
        rd(ADDR_TCTRL, 32'h0F, RESP_OKAY);
        rd(ADDR_IRQ_STATUS, 32'h03, RESP_OKAY);
        src.vector(1'b1);
        settle;
        chk("pend_b", pend_b, 1'b0);
        chk("pend_a", pend_a, 1'b1);
        src.vector(1'b0);
        settle;
        chk("pend_a", pend_a, 1'b0);
        // software vector acknowledge clears only the channel it names
        src.drive(8'h22);
        src.drive(8'h00);
        settle;
        wr(ADDR_VECTOR_ACK, 32'h01, RESP_OKAY);
        settle;
        chk("pend_a", pend_a, 1'b0);
        chk("pend_b", pend_b, 1'b1);
        wr(ADDR_IRQ_ENABLE, 32'h00, RESP_OKAY);
        settle;
        chk("irq", irq, 1'b0);
        wr(ADDR_IRQ_ENABLE, 32'h02, RESP_OKAY);
        rd(ADDR_IRQ_ENABLE, 32'h02, RESP_OKAY);
        chk("irq", irq, 1'b1);
        // only byte lane 0 writes a register
        wstrb <= 4'hE;
        wr(ADDR_IRQ_ENABLE, 32'h00, RESP_OKAY);
        wstrb <= 4'hF;
        rd(ADDR_IRQ_ENABLE, 32'h02, RESP_OKAY);
        wr(ADDR_IRQ_CLEAR, 32'h02, RESP_OKAY);
        settle;
        chk("irq", irq, 1'b0);
        rd(ADDR_IRQ_STATUS, 32'h01, RESP_OKAY);
        rd(ADDR_IRQ_CLEAR, 32'h00, RESP_OKAY);
        final_report;
    end
endmodule // test_ext_irq_conditioner
`default_nettype wire
